// file: adct_pkg.sv
package adct_pkg;

   // Clock rate and the long status deadlines
   localparam longint unsigned CLK_HZ       = 100_000_000;
   localparam longint unsigned T_READY_S    = 31;
   localparam longint unsigned T_CMD_S      = 30;
   localparam longint unsigned READY_CYC    = T_READY_S * CLK_HZ;
   localparam longint unsigned CMD_CYC      = T_CMD_S * CLK_HZ;
   localparam int unsigned     SECT_WORDS   = 256;

   // Register port
   localparam int unsigned     ADDR_W       = 4;
   localparam int unsigned     DATA_W       = 16;
   localparam logic [3:0]      A_DATA       = 4'h0;
   localparam logic [3:0]      A_ERR_FEAT   = 4'h1;
   localparam logic [3:0]      A_SCNT       = 4'h2;
   localparam logic [3:0]      A_SNUM       = 4'h3;
   localparam logic [3:0]      A_CYL_LO     = 4'h4;
   localparam logic [3:0]      A_CYL_HI     = 4'h5;
   localparam logic [3:0]      A_DEV_HEAD   = 4'h6;
   localparam logic [3:0]      A_STAT_CMD   = 4'h7;
   localparam logic [3:0]      A_CTRL       = 4'hE;

   // Status, error and device control bit positions
   localparam int unsigned     ST_BSY       = 7;
   localparam int unsigned     ST_RDY       = 6;
   localparam int unsigned     ST_DSC       = 4;
   localparam int unsigned     ST_DRQ       = 3;
   localparam int unsigned     ST_ERR       = 0;
   localparam int unsigned     ER_ABT       = 2;
   localparam int unsigned     CT_SRST      = 2;
   localparam int unsigned     CT_NIEN      = 1;
   localparam logic [8:0]      SECT_MAX     = 9'h100;

   // Opcodes that the decoder treats specially
   localparam logic [7:0]      OP_WRITE_SECT  = 8'h30;
   localparam logic [7:0]      OP_WRITE_VERIFY = 8'h3C;
   localparam logic [7:0]      OP_SET_FEAT    = 8'hEF;

   // Feature subcodes
   localparam logic [7:0]      FS_WC_ON     = 8'h02;
   localparam logic [7:0]      FS_XFER_MODE = 8'h03;
   localparam logic [7:0]      FS_APM_ON    = 8'h05;
   localparam logic [7:0]      FS_PUIS_ON   = 8'h06;
   localparam logic [7:0]      FS_SPINUP    = 8'h07;
   localparam logic [7:0]      FS_OFS_ON    = 8'h09;
   localparam logic [7:0]      FS_AAM_ON    = 8'h42;
   localparam logic [7:0]      FS_ECC_LONG  = 8'h44;
   localparam logic [7:0]      FS_RLA_OFF   = 8'h55;
   localparam logic [7:0]      FS_REL_ON    = 8'h5D;
   localparam logic [7:0]      FS_NOREV_ON  = 8'h66;
   localparam logic [7:0]      FS_WC_OFF    = 8'h82;
   localparam logic [7:0]      FS_APM_OFF   = 8'h85;
   localparam logic [7:0]      FS_PUIS_OFF  = 8'h86;
   localparam logic [7:0]      FS_OFS_OFF   = 8'h89;
   localparam logic [7:0]      FS_RLA_ON    = 8'hAA;
   localparam logic [7:0]      FS_ECC_4     = 8'hBB;
   localparam logic [7:0]      FS_AAM_OFF   = 8'hC2;
   localparam logic [7:0]      FS_NOREV_OFF = 8'hCC;
   localparam logic [7:0]      FS_REL_OFF   = 8'hDD;

   typedef enum logic [2:0] {
      CAT_NONDATA,
      CAT_PIO_IN,
      CAT_PIO_OUT,
      CAT_DMA,
      CAT_SETFEAT,
      CAT_REJECT
   } adct_cat_e;

   typedef struct packed {
      logic       valid;
      logic [7:0] opcode;
      adct_cat_e  cat;
      logic       retry_dis;
      logic [7:0] count;
   } adct_cmd_s;

   typedef struct packed {
      logic       lookahead;
      logic       long_ecc;
      logic       no_revert;
      logic       addr_offset;
      logic       apm;
      logic       wcache;
      logic       aam;
      logic       rel_intr;
      logic       puis;
      logic       spinup;
      logic [7:0] xfer_mode;
   } adct_feat_s;

   localparam adct_feat_s FEAT_DEFAULT = '{
      lookahead: 1'b1, long_ecc: 1'b0, no_revert: 1'b0, addr_offset: 1'b0,
      apm: 1'b0, wcache: 1'b1, aam: 1'b0, rel_intr: 1'b0, puis: 1'b0,
      spinup: 1'b0, xfer_mode: 8'h00};

endpackage

// file: adct_deadline.sv
`timescale 1ns/10ps
module adct_deadline #(
   parameter int unsigned W = 32
) (
   input  wire logic         i_core_clk,  // Core clock
   input  wire logic         i_srst,      // Synchronous reset
   input  wire logic         i_start,     // Load and arm
   input  wire logic [W-1:0] i_limit,     // Cycles until expiry
   output logic              o_expired    // One-cycle expiry pulse
);

   logic [W-1:0] count;
   logic         armed;
   wire          last = armed && (count <= {{(W-1){1'b0}}, 1'b1});

   always_ff @(posedge i_core_clk)
   begin
      if (i_srst)
      begin
         count     <= '0;
         armed     <= 1'b0;
         o_expired <= 1'b0;
      end
      else if (i_start)
      begin
         count     <= i_limit;
         armed     <= 1'b1;
         o_expired <= 1'b0;
      end
      else
      begin
         count     <= armed ? count - {{(W-1){1'b0}}, 1'b1} : count;
         armed     <= armed && !last;
         o_expired <= last;
      end
   end

endmodule

// file: adct_core.sv
// Summary of operation
// - Busy within 400 ns of any reset
// - Ready within 31 s after bus or soft reset ends; after power-on reset, ready only on back end ready
// - Busy within 400 ns of opcode write
// - Data-in: DRQ and interrupt within 30 s
// - Data-in: busy after 256th word read
// - Data-out: DRQ within 700 us of busy
// - Data-out: busy after 256th word write
// - Data-out block: ready and interrupt in 30 s
// - Non-data: completion interrupt within 30 s
// - Write verify runs as plain write sectors
// - Reserved opcodes are not implemented
// - Removable, CFA, packet, reset opcodes unsupported
// - Accept all DMA and queued DMA opcodes
// - Subcodes 55h/AAh switch read look-ahead
// - Subcodes 44h/BBh pick long/4-byte ECC
// - Subcodes 66h/CCh control reverting defaults
// - Subcodes 09h/89h switch address offset
// - APM 05h/85h, write cache 02h/82h
// - AAM 42h/C2h, release interrupt 5Dh/DDh
// - Standby power-up 06h/86h, spin-up 07h
// - Service, notification, unlisted subcodes other than 03h (transfer mode) unsupported
// - Bit 0 of dual opcodes disables retry
// - Power-on default is 4-byte ECC
`timescale 1ns/10ps
module adct_core #(
   parameter int unsigned P_READY_CYC  = 32'(adct_pkg::READY_CYC),
   parameter int unsigned P_CMD_CYC    = 32'(adct_pkg::CMD_CYC),
   parameter int unsigned P_SECT_WORDS = adct_pkg::SECT_WORDS
) (
   input  wire logic                           i_core_clk,    // Core clock
   input  wire logic                           i_srst,        // Power-on reset
   input  wire logic                           i_hard_rst,    // Bus reset line
   input  wire logic [adct_pkg::ADDR_W-1:0]    i_addr,        // Register address
   input  wire logic [adct_pkg::DATA_W-1:0]    i_wdata,       // Write data
   input  wire logic                           i_wr,          // Write strobe
   input  wire logic                           i_rd,          // Read strobe
   input  wire logic                           i_init_done,   // Back end ready
   input  wire logic                           i_media_ready, // Sector done
   input  wire logic [adct_pkg::DATA_W-1:0]    i_media_word,  // Read word
   output logic      [adct_pkg::DATA_W-1:0]    o_rdata,       // Read data
   output logic                                o_intrq,       // Interrupt
   output adct_pkg::adct_cmd_s                 o_cmd,         // Command issue
   output logic                                o_word_rd,     // Word taken
   output logic                                o_word_wr,     // Word given
   output logic      [adct_pkg::DATA_W-1:0]    o_wdata,       // Given word
   output adct_pkg::adct_feat_s                o_feat         // Feature set
);

   typedef enum logic [2:0] {
      S_RESET_WAIT,
      S_SRST_HOLD,
      S_IDLE,
      S_EXEC,
      S_DRQ_IN,
      S_DRQ_OUT
   } adct_state_e;

   // Opcode classification
   function automatic adct_pkg::adct_cat_e classify(input logic [7:0] op);
      adct_pkg::adct_cat_e c;
      c = adct_pkg::CAT_REJECT;
      case (op)
         8'h20, 8'h21, 8'h22, 8'h23, 8'hC4, 8'hE4, 8'hEC:
            c = adct_pkg::CAT_PIO_IN;
         8'h30, 8'h31, 8'h32, 8'h33, 8'h3C, 8'h50, 8'hC5, 8'hE8,
         8'hF1, 8'hF2, 8'hF3, 8'hF4, 8'hF6:
            c = adct_pkg::CAT_PIO_OUT;
         8'hC7, 8'hC8, 8'hC9, 8'hCA, 8'hCB, 8'hCC:
            c = adct_pkg::CAT_DMA;
         8'h00, 8'h40, 8'h41, 8'h90, 8'h91, 8'hA2, 8'hB0, 8'hC6,
         8'hE0, 8'hE1, 8'hE2, 8'hE3, 8'hE5, 8'hE6, 8'hE7,
         8'hF0, 8'hF5, 8'hF7, 8'hF8, 8'hF9:
            c = adct_pkg::CAT_NONDATA;
         adct_pkg::OP_SET_FEAT:
            c = adct_pkg::CAT_SETFEAT;
         default:
            if (op[7:4] == 4'h1 || op[7:4] == 4'h7)
               c = adct_pkg::CAT_NONDATA;
      endcase
      return c;
   endfunction

   // Opcode pairs whose low bit turns retries off
   function automatic logic dual_opcode(input logic [7:0] op);
      return (op[7:2] == 6'b0010_00) || (op[7:2] == 6'b0011_00) ||
             (op[7:1] == 7'b0100_000) || (op[7:2] == 6'b1100_10);
   endfunction

   function automatic logic feat_known(input logic [7:0] sub);
      return sub inside {adct_pkg::FS_WC_ON, adct_pkg::FS_XFER_MODE, adct_pkg::FS_APM_ON,
         adct_pkg::FS_PUIS_ON, adct_pkg::FS_SPINUP, adct_pkg::FS_OFS_ON,
         adct_pkg::FS_AAM_ON, adct_pkg::FS_ECC_LONG, adct_pkg::FS_RLA_OFF,
         adct_pkg::FS_REL_ON, adct_pkg::FS_NOREV_ON, adct_pkg::FS_WC_OFF,
         adct_pkg::FS_APM_OFF, adct_pkg::FS_PUIS_OFF, adct_pkg::FS_OFS_OFF,
         adct_pkg::FS_RLA_ON, adct_pkg::FS_ECC_4, adct_pkg::FS_AAM_OFF,
         adct_pkg::FS_NOREV_OFF, adct_pkg::FS_REL_OFF};
   endfunction

   adct_state_e          state;
   adct_state_e          next_state;
   adct_pkg::adct_cat_e  cat;
   adct_pkg::adct_feat_s next_feat;
   logic [7:0]           feat_reg;
   logic [7:0]           scnt;
   logic [7:0]           snum;
   logic [7:0]           cyl_lo;
   logic [7:0]           cyl_hi;
   logic [7:0]           dev_head;
   logic                 srst_bit;
   logic                 nien;
   logic                 abort;
   logic                 first_out;
   logic                 pend;
   logic [8:0]           sect_left;
   logic [8:0]           word_cnt;
   logic [7:0]           cur_op;
   logic                 tmr_expired;
   logic [adct_pkg::DATA_W-1:0] read_word;

   // Access decode
   wire at_cmd   = i_addr == adct_pkg::A_STAT_CMD;
   wire is_busy  = state == S_RESET_WAIT || state == S_SRST_HOLD || state == S_EXEC;
   wire wr_ctrl  = i_wr && i_addr == adct_pkg::A_CTRL;
   wire wr_blk   = i_wr && state == S_IDLE && i_addr != adct_pkg::A_CTRL;
   wire wr_cmd   = wr_blk && at_cmd;
   wire rd_stat  = i_rd && at_cmd;
   wire rd_data  = i_rd && i_addr == adct_pkg::A_DATA && state == S_DRQ_IN;
   wire wr_data  = i_wr && i_addr == adct_pkg::A_DATA && state == S_DRQ_OUT;
   wire last_wd  = word_cnt == 9'(P_SECT_WORDS - 1);
   wire srst_now = wr_ctrl ? i_wdata[adct_pkg::CT_SRST] : srst_bit;
   wire srst_set = wr_ctrl && i_wdata[adct_pkg::CT_SRST] && !srst_bit;
   wire enter_rst = srst_set || (i_hard_rst && state != S_SRST_HOLD);
   wire feat_ok  = feat_known(feat_reg);
   adct_pkg::adct_cat_e new_cat;
   assign new_cat = classify(i_wdata[7:0]);

   // Status as the host sees it
   wire [7:0] status = {is_busy, !is_busy, 1'b0, !is_busy,
                        state == S_DRQ_IN || state == S_DRQ_OUT, 2'b00, abort};
   wire [7:0] err_reg = abort ? 8'(1 << adct_pkg::ER_ABT) : 8'h00;

   // Completion of the exec phase
   wire exec_fail = (cat == adct_pkg::CAT_REJECT) ||
                    (cat == adct_pkg::CAT_SETFEAT && !feat_ok) ||
                    (tmr_expired && !(cat == adct_pkg::CAT_PIO_OUT && first_out));
   wire in_done   = cat == adct_pkg::CAT_PIO_IN && sect_left == 9'h000;

   always_comb
   begin
      next_state = state;
      if (enter_rst || (srst_now && state != S_SRST_HOLD))
         next_state = S_SRST_HOLD;
      else
      begin
         case (state)
            S_RESET_WAIT:
               if (i_init_done || tmr_expired)
                  next_state = S_IDLE;
            S_SRST_HOLD:
               if (!srst_now && !i_hard_rst)
                  next_state = S_RESET_WAIT;
            S_IDLE:
               if (wr_cmd)
                  next_state = S_EXEC;
            S_EXEC:
            begin
               if (cat == adct_pkg::CAT_PIO_OUT && first_out)
                  next_state = S_DRQ_OUT;
               else if (exec_fail || in_done || cat == adct_pkg::CAT_SETFEAT)
                  next_state = S_IDLE;
               else if (i_media_ready)
               begin
                  if (cat == adct_pkg::CAT_PIO_IN)
                     next_state = S_DRQ_IN;
                  else if (cat == adct_pkg::CAT_PIO_OUT && sect_left != 9'h000)
                     next_state = S_DRQ_OUT;
                  else
                     next_state = S_IDLE;
               end
            end
            S_DRQ_IN:
               if (rd_data && last_wd)
                  next_state = S_EXEC;
            S_DRQ_OUT:
               if (wr_data && last_wd)
                  next_state = S_EXEC;
            default:
               next_state = S_RESET_WAIT;
         endcase
      end
   end

   // Entry to a waiting state restarts its deadline
   wire tmr_start = next_state != state &&
                    (next_state == S_EXEC || next_state == S_RESET_WAIT);
   wire [31:0] tmr_limit = next_state == S_RESET_WAIT ? P_READY_CYC : P_CMD_CYC;

   // Interrupt on every exit from exec except to reset hold, the end of a read and the first write request
   wire intr_set = state == S_EXEC && next_state != S_EXEC &&
                   next_state != S_SRST_HOLD && !(in_done && !exec_fail) &&
                   !(cat == adct_pkg::CAT_PIO_OUT && first_out);
   wire next_pend = intr_set || (pend && !rd_stat && !wr_cmd);

   always_comb
   begin
      next_feat = o_feat;
      next_feat.spinup = 1'b0;
      if (i_srst)
         next_feat = adct_pkg::FEAT_DEFAULT;
      else if (enter_rst && !o_feat.no_revert)
         next_feat = adct_pkg::FEAT_DEFAULT;
      else if (state == S_EXEC && cat == adct_pkg::CAT_SETFEAT)
      begin
         case (feat_reg)
            adct_pkg::FS_RLA_OFF:   next_feat.lookahead   = 1'b0;
            adct_pkg::FS_RLA_ON:    next_feat.lookahead   = 1'b1;
            adct_pkg::FS_ECC_LONG:  next_feat.long_ecc    = 1'b1;
            adct_pkg::FS_ECC_4:     next_feat.long_ecc    = 1'b0;
            adct_pkg::FS_NOREV_ON:  next_feat.no_revert   = 1'b1;
            adct_pkg::FS_NOREV_OFF: next_feat.no_revert   = 1'b0;
            adct_pkg::FS_OFS_ON:    next_feat.addr_offset = 1'b1;
            adct_pkg::FS_OFS_OFF:   next_feat.addr_offset = 1'b0;
            adct_pkg::FS_APM_ON:    next_feat.apm         = 1'b1;
            adct_pkg::FS_APM_OFF:   next_feat.apm         = 1'b0;
            adct_pkg::FS_WC_ON:     next_feat.wcache      = 1'b1;
            adct_pkg::FS_WC_OFF:    next_feat.wcache      = 1'b0;
            adct_pkg::FS_AAM_ON:    next_feat.aam         = 1'b1;
            adct_pkg::FS_AAM_OFF:   next_feat.aam         = 1'b0;
            adct_pkg::FS_REL_ON:    next_feat.rel_intr    = 1'b1;
            adct_pkg::FS_REL_OFF:   next_feat.rel_intr    = 1'b0;
            adct_pkg::FS_PUIS_ON:   next_feat.puis        = 1'b1;
            adct_pkg::FS_PUIS_OFF:  next_feat.puis        = 1'b0;
            adct_pkg::FS_SPINUP:    next_feat.spinup      = 1'b1;
            adct_pkg::FS_XFER_MODE: next_feat.xfer_mode   = scnt;
            default:                next_feat = o_feat;
         endcase
      end
   end

   // Read mux, captured for the cycle after the strobe
   always_comb
   begin
      case (i_addr)
         adct_pkg::A_DATA:     read_word = state == S_DRQ_IN ? i_media_word : '0;
         adct_pkg::A_ERR_FEAT: read_word = {8'h00, err_reg};
         adct_pkg::A_SCNT:     read_word = {8'h00, scnt};
         adct_pkg::A_SNUM:     read_word = {8'h00, snum};
         adct_pkg::A_CYL_LO:   read_word = {8'h00, cyl_lo};
         adct_pkg::A_CYL_HI:   read_word = {8'h00, cyl_hi};
         adct_pkg::A_DEV_HEAD: read_word = {8'h00, dev_head};
         adct_pkg::A_STAT_CMD,
         adct_pkg::A_CTRL:     read_word = {8'h00, status};
         default:              read_word = '0;
      endcase
   end

   adct_deadline #(.W (32)) u_deadline (
      .i_core_clk (i_core_clk),
      .i_srst     (i_srst),
      .i_start    (tmr_start),
      .i_limit    (tmr_limit),
      .o_expired  (tmr_expired)
   );

   always_ff @(posedge i_core_clk)
   begin
      if (i_srst)
      begin
         feat_reg <= 8'h00;
         scnt     <= 8'h00;
         snum     <= 8'h00;
         cyl_lo   <= 8'h00;
         cyl_hi   <= 8'h00;
         dev_head <= 8'h00;
         srst_bit <= 1'b0;
         nien     <= 1'b0;
      end
      else if (wr_blk)
      begin
         case (i_addr)
            adct_pkg::A_ERR_FEAT: feat_reg <= i_wdata[7:0];
            adct_pkg::A_SCNT:     scnt     <= i_wdata[7:0];
            adct_pkg::A_SNUM:     snum     <= i_wdata[7:0];
            adct_pkg::A_CYL_LO:   cyl_lo   <= i_wdata[7:0];
            adct_pkg::A_CYL_HI:   cyl_hi   <= i_wdata[7:0];
            adct_pkg::A_DEV_HEAD: dev_head <= i_wdata[7:0];
            default:              scnt     <= scnt;
         endcase
      end
      else if (wr_ctrl)
      begin
         srst_bit <= i_wdata[adct_pkg::CT_SRST];
         nien     <= i_wdata[adct_pkg::CT_NIEN];
      end
   end

   // Command capture and counters; abort holds until the next command, a new event wins
   always_ff @(posedge i_core_clk)
   begin
      if (i_srst || enter_rst)
      begin
         cat       <= adct_pkg::CAT_NONDATA;
         cur_op    <= 8'h00;
         first_out <= 1'b0;
         sect_left <= 9'h000;
         word_cnt  <= 9'h000;
         abort     <= 1'b0;
         pend      <= 1'b0;
      end
      else
      begin
         abort <= (state == S_EXEC && exec_fail) || (abort && !wr_cmd);
         pend  <= next_pend;
         if (wr_cmd)
         begin
            cat       <= new_cat;
            cur_op    <= i_wdata[7:0];
            first_out <= 1'b1;
            sect_left <= scnt == 8'h00 ? adct_pkg::SECT_MAX : {1'b0, scnt};
            word_cnt  <= 9'h000;
         end
         else
         begin
            if (state == S_EXEC && next_state == S_DRQ_OUT)
               first_out <= 1'b0;
            if (rd_data || wr_data)
               word_cnt <= last_wd ? 9'h000 : word_cnt + 9'h001;
            if ((rd_data || wr_data) && last_wd)
               sect_left <= sect_left - 9'h001;
         end
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_srst)
      begin
         o_rdata   <= '0;
         o_intrq   <= 1'b0;
         o_cmd     <= '0;
         o_word_rd <= 1'b0;
         o_word_wr <= 1'b0;
         o_wdata   <= '0;
         o_feat    <= adct_pkg::FEAT_DEFAULT;
         state     <= S_RESET_WAIT;
      end
      else
      begin
         o_rdata         <= i_rd ? read_word : '0;
         o_intrq         <= next_pend && !(wr_ctrl ? i_wdata[adct_pkg::CT_NIEN] : nien);
         o_cmd.valid     <= wr_cmd && new_cat != adct_pkg::CAT_REJECT &&
                            new_cat != adct_pkg::CAT_SETFEAT;
         o_cmd.opcode    <= i_wdata[7:0] == adct_pkg::OP_WRITE_VERIFY ?
                            adct_pkg::OP_WRITE_SECT : i_wdata[7:0];
         o_cmd.cat       <= new_cat;
         o_cmd.retry_dis <= dual_opcode(i_wdata[7:0]) && i_wdata[0];
         o_cmd.count     <= scnt;
         o_word_rd       <= rd_data;
         o_word_wr       <= wr_data;
         o_wdata         <= wr_data ? i_wdata : o_wdata;
         o_feat          <= next_feat;
         state           <= next_state;
      end
   end

endmodule

// file: adct_core_properties.sv
`timescale 1ns/10ps
module adct_core_properties (
   input wire logic                 i_core_clk, // Clock
   input wire logic                 i_srst,     // Reset
   input wire logic                 i_hard_rst, // Bus reset
   input wire logic [3:0]           i_addr,     // Address
   input wire logic [15:0]          i_wdata,    // Write data
   input wire logic                 i_wr,       // Write strobe
   input wire logic                 i_rd,       // Read strobe
   input wire logic [15:0]          o_rdata,    // Read data
   input wire adct_pkg::adct_cmd_s  o_cmd,      // Command issue
   input wire logic                 o_word_rd,  // Word taken
   input wire adct_pkg::adct_feat_s o_feat      // Feature set
);
   logic [7:0] last_feat = 8'h00;
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_srst);
   always_ff @(posedge i_core_clk)
   begin
      if (i_wr && i_addr == adct_pkg::A_ERR_FEAT)
         last_feat <= i_wdata[7:0];
   end
   a_feat_default: assert property (disable iff (1'b0)
      i_srst |=> o_feat == adct_pkg::FEAT_DEFAULT) else $error("features not default");
   a_hard_busy: assert property ($past(i_hard_rst) && i_hard_rst && i_rd
      && i_addr == adct_pkg::A_STAT_CMD |=> o_rdata[7]) else $error("busy missing");
   a_cmd_cause: assert property (o_cmd.valid |->
      $past(i_wr && i_addr == adct_pkg::A_STAT_CMD)) else $error("command without write");
   a_wv_write: assert property (o_cmd.valid && $past(i_wdata[7:0]) == 8'h3C |->
      o_cmd.opcode == 8'h30 && o_cmd.cat == adct_pkg::CAT_PIO_OUT) else $error("bad write verify");
   a_rsvd_silent: assert property (i_wr && i_addr == 4'h7 && i_wdata[7:0] inside
      {[8'h94:8'h99], 8'hFB, 8'h08, 8'hA0, 8'hEE} |=> !o_cmd.valid) else $error("reserved issued");
   a_dma_cat: assert property (o_cmd.valid && o_cmd.opcode inside {[8'hC7:8'hCC]}
      |-> o_cmd.cat == adct_pkg::CAT_DMA) else $error("dma category wrong");
   a_retry_flag: assert property (o_cmd.valid && o_cmd.opcode inside {[8'hC8:8'hCB]}
      |-> o_cmd.retry_dis == o_cmd.opcode[0]) else $error("retry flag wrong");
   a_rla_cause: assert property ($fell(o_feat.lookahead) |-> last_feat == 8'h55)
      else $error("look-ahead off without 55");
   a_ecc_cause: assert property ($rose(o_feat.long_ecc) |-> last_feat == 8'h44)
      else $error("long ecc without 44");
   a_spin_pulse: assert property (o_feat.spinup |=> !o_feat.spinup)
      else $error("spin-up not a pulse");
   a_word_cause: assert property (o_word_rd |-> $past(i_rd && i_addr == 4'h0))
      else $error("word taken without read");
endmodule
bind adct_core adct_core_properties u_adct_core_properties (.i_core_clk, .i_srst, .i_hard_rst,
   .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_cmd, .o_word_rd, .o_feat);

// file: adct_backend_model.sv
`timescale 1ns/10ps
module adct_backend_model #(
   parameter int P_WORDS = 4
) (
   input  wire logic                i_core_clk,    // Clock
   input  wire logic                i_hold,        // Stall init
   input  wire logic                i_mute,        // Never answer
   input  wire logic [7:0]          i_lat,         // Answer delay
   input  wire adct_pkg::adct_cmd_s i_cmd,         // Command issue
   input  wire logic                i_word_rd,     // Word taken
   input  wire logic                i_word_wr,     // Word given
   output logic                     o_init_done,   // Init done
   output logic                     o_media_ready, // Done pulse
   output logic [15:0]              o_media_word   // Read word
);
   int         wait_c = -1;
   int         nwr = 0;
   logic [7:0] nrd = 8'h00;
   assign o_init_done  = !i_hold;
   // Word moves on after every take so a stale read shows up
   assign o_media_word = {8'hD0, nrd};
   initial o_media_ready = 1'b0;
   always @(posedge i_core_clk)
   begin
      o_media_ready <= wait_c == 0 && !i_mute;
      if (wait_c >= 0) wait_c <= wait_c - 1;
      if (i_word_rd) nrd <= nrd + 8'h01;
      if (i_word_wr) nwr <= (nwr + 1) % P_WORDS;
      if ((i_cmd.valid && i_cmd.cat != adct_pkg::CAT_PIO_OUT) || (i_word_wr && nwr == P_WORDS - 1))
         wait_c <= i_lat;
   end
endmodule

// file: tb_adct_core.sv
`timescale 1ns/10ps
module tb_adct_core;
   logic                 i_core_clk = 0, i_srst = 1, hard = 0, wr = 0, rd = 0, hold = 1, mute = 0;
   logic [3:0]           addr = 4'h0;
   logic [7:0]           lat = 8'h05;
   logic [15:0]          wdata = 16'h0000, rdata, m_word, o_wd, d;
   logic                 intrq, word_rd, word_wr, init_done, m_rdy;
   adct_pkg::adct_cmd_s  cmd, c;
   adct_pkg::adct_feat_s feat;
   int                   num_errors = 0, n_checks = 0, cyc = 0;
   logic [23:0]          tbl [0:18] = '{24'h51_0094, 24'h51_0099, 24'h51_00FB, 24'h51_0008,
      24'h51_00A0, 24'h51_00EE, 24'h51_0003, 24'h51_0001, 24'h51_5EEF, 24'h51_95EF, 24'h51_EEEF,
      24'h51_13EF, 24'h50_07EF, 24'h50_00C7, 24'h50_00C8, 24'h50_00C9, 24'h50_00CA, 24'h50_00CB,
      24'h50_00CC};
   logic [7:0]           fs [0:17] = '{8'h55, 8'hAA, 8'h44, 8'hBB, 8'h66, 8'hCC, 8'h09, 8'h89,
      8'h05, 8'h85, 8'h82, 8'h02, 8'h42, 8'hC2, 8'h5D, 8'hDD, 8'h06, 8'h86};
   adct_core #(.P_READY_CYC(50), .P_CMD_CYC(50), .P_SECT_WORDS(4)) u_adct_core (.i_core_clk,
      .i_srst, .i_hard_rst(hard), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
      .i_init_done(init_done), .i_media_ready(m_rdy), .i_media_word(m_word), .o_rdata(rdata),
      .o_intrq(intrq), .o_cmd(cmd), .o_word_rd(word_rd), .o_word_wr(word_wr), .o_wdata(o_wd),
      .o_feat(feat));
   adct_backend_model #(.P_WORDS(4)) u_adct_backend_model (.i_core_clk, .i_hold(hold),
      .i_mute(mute), .i_lat(lat), .i_cmd(cmd), .i_word_rd(word_rd), .i_word_wr(word_wr),
      .o_init_done(init_done), .o_media_ready(m_rdy), .o_media_word(m_word));
   initial forever #5 i_core_clk = ~i_core_clk;
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wrt(logic [3:0] a, logic [15:0] v);
      @(posedge i_core_clk) {wr, addr, wdata} <= {1'b1, a, v};
      @(posedge i_core_clk) wr <= 1'b0;
   endtask
   task automatic rdt(logic [3:0] a, output logic [15:0] v);
      @(posedge i_core_clk) {rd, addr} <= {1'b1, a};
      @(posedge i_core_clk) rd <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic finish_cmd(logic [7:0] st);
      for (int k = 0; k < 200 && intrq !== 1'b1; k++) @(posedge i_core_clk);
      chk("intrq", 1, intrq);
      rdt(4'h7, d);
      chk("status", st, d);
      @(posedge i_core_clk) #1 chk("intrq_clr", 0, intrq);
      if (st[0]) rdt(4'h1, d);
      if (st[0]) chk("error", 16'h0004, d);
   endtask
   task automatic wait_idle();
      d = 16'h0000;
      for (int k = 0; k < 100 && d !== 16'h0050; k++) rdt(4'h7, d);
      chk("ready", 16'h0050, d);
   endtask
   task automatic test_done();
      if (num_errors == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   always @(posedge i_core_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         num_errors++;
         test_done();
      end
   end
   initial
   begin
      repeat (5) @(posedge i_core_clk);
      i_srst <= 1'b0;
      rdt(4'h7, d);
      chk("por_busy", 16'h0080, d);
      chk("feat_por", 32'(adct_pkg::FEAT_DEFAULT), 32'(feat));
      hold <= 1'b0;
      wait_idle();
      for (int s = 0; s < 2; s++)
      begin
         lat <= s ? 8'h28 : 8'h02;
         wrt(4'h7, 16'h00E7);
         rdt(4'h7, d);
         chk("cmd_busy", 16'h0080, d);
         finish_cmd(8'h50);
      end
      for (int i = 0; i < 19; i++)
      begin
         wrt(4'h1, {8'h00, tbl[i][15:8]});
         wrt(4'h7, {8'h00, tbl[i][7:0]});
         #1 c = cmd;
         chk("cmd_valid", !tbl[i][16] && tbl[i][7:0] != 8'hEF, c.valid);
         if (tbl[i][7:4] == 4'hC) chk("dma_cat", adct_pkg::CAT_DMA, c.cat);
         if (tbl[i][7:2] == 6'h32) chk("retry", tbl[i][0], c.retry_dis);
         finish_cmd(tbl[i][23:16]);
      end
      // Each subcode pair is applied in turn; the first of a pair flips one bit, the second restores the default
      for (int i = 0; i < 18; i++)
      begin
         wrt(4'h1, {8'h00, fs[i]});
         wrt(4'h7, 16'h00EF);
         finish_cmd(8'h50);
         chk("feat", 32'(adct_pkg::FEAT_DEFAULT ^ ((i % 2) ? 18'h0 : 18'h2_0000 >> (i / 2))),
            32'(feat));
      end
      wrt(4'h2, 16'h0001);
      wrt(4'h7, 16'h0020);
      finish_cmd(8'h58);
      for (int k = 0; k < 4; k++) rdt(4'h0, d);
      chk("last_word", 16'hD003, d);
      rdt(4'h7, d);
      chk("in_done", 17'h0_0050, {intrq, d});
      wrt(4'h2, 16'h0001);
      wrt(4'h7, 16'h003C);
      #1 chk("wv_op", 8'h30, cmd.opcode);
      rdt(4'hE, d);
      chk("out_drq", 17'h0_0058, {intrq, d});
      for (int k = 0; k < 4; k++) wrt(4'h0, 16'hB000 + 16'(k));
      #1 chk("out_word", 16'hB003, o_wd);
      finish_cmd(8'h50);
      wrt(4'h1, 16'h0055);
      wrt(4'h7, 16'h00EF);
      finish_cmd(8'h50);
      mute <= 1'b1;
      wrt(4'h7, 16'h00E7);
      finish_cmd(8'h51);
      wrt(4'hE, 16'h0004);
      wrt(4'hE, 16'h0000);
      wait_idle();
      chk("feat_revert", 32'(adct_pkg::FEAT_DEFAULT), 32'(feat));
      mute <= 1'b0;
      wrt(4'h7, 16'h00E7);
      finish_cmd(8'h50);
      @(posedge i_core_clk) hard <= 1'b1;
      rdt(4'h7, d);
      chk("hard_busy", 16'h0080, d);
      @(posedge i_core_clk) hard <= 1'b0;
      wait_idle();
      test_done();
   end
endmodule
